/* common/eeprom_pkg.sv */
// shared constants and types of the two-wire eeprom slave port
// assumes a 50 MHz system clock and a free-running link sampling clock

package eeprom_pkg;

	// ==========================================================
	// addressing
	localparam logic [3:0] TYPE_CODE  = 4'ha;
	localparam int         MEM_BYTES  = 256;
	localparam int         PAGE_BYTES = 16;
	localparam logic [7:0] PTR_RESET  = 8'h00;
	localparam logic [3:0] ACK_SLOT   = 4'h8;

	// ==========================================================
	// timing
	localparam int CLK_KHZ   = 50000;
	localparam int TW_MS     = 4;
	localparam int TW_CYCLES = TW_MS * CLK_KHZ;

	// ==========================================================
	// carriers and states
	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       wp;
		logic [2:0] sel;
	} pin_t;

	localparam pin_t PINS_RESET = '{scl: 1'b1, sda: 1'b1, wp: 1'b0, sel: 3'h0};

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_WORD,
		ST_DATA,
		ST_READ
	} link_state_t;

endpackage

/* rtl/eeprom_slave.sv */
// two-wire serial eeprom slave: bus decode, 256-byte array, page buffer
// assumes scl/sda/wp/select pins are asynchronous; link_clk runs free
// and much faster than scl; the bench resolves the open-drain wire

`timescale 1ns/1ns
`default_nettype none

// How it works
// R1 - start is sda falling while scl high
// R2 - stop is sda rising while scl high
// R3 - master keeps sda stable while scl high
// R4 - matching address byte acked on ninth clock
// R5 - upper address nibble must equal type code
// R6 - bits three to one match select pins
// R7 - address lsb one reads, zero writes
// R8 - first write byte loads address pointer
// R9 - stop after write starts programming cycle
// R10 - no response while programming runs
// R11 - page write of up to sixteen bytes
// R12 - write increments low four address bits only
// R13 - extra bytes wrap and overwrite page buffer
// R14 - no ack to address while busy
// R15 - ack returns once programming done
// R16 - read address alone returns counter byte
// R17 - counter wraps past last byte to zero
// R18 - master ends read with nack, stop
// R19 - random read: dummy write then restart
// R20 - start after clocking out resets logic
// R21 - standby after reset, stop, or programming
// R22 - array is 256 bytes, sixteen-byte pages
// R23 - each master ack sends next byte
// R24 - write protect high refuses writes
// R25 - msb first, sample rising, release otherwise
// R26 - start mid-transfer aborts to address reception
module eeprom_slave #(
	parameter int WRITE_CYCLES = eeprom_pkg::TW_CYCLES
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic link_clk,
	input  wire logic scl,
	input  wire logic sda_in,
	output var  logic sda_out,
	output var  logic sda_oe,
	input  wire logic wp,
	input  wire logic hw_select_bit0,
	input  wire logic hw_select_bit1,
	input  wire logic hw_select_bit2,
	output var  logic write_busy
);
	import eeprom_pkg::*;

	localparam int CW = $clog2(WRITE_CYCLES + 1);

	// ==========================================================
	// link domain: pin synchronisers and condition detect
	pin_t        pins;
	pin_t        pin_s1;
	pin_t        pin_s2;
	pin_t        pin_last;
	logic        start;
	logic        stop;
	logic        rise;
	logic        fall;

	assign pins = '{scl: scl, sda: sda_in, wp: wp,
		sel: {hw_select_bit2, hw_select_bit1, hw_select_bit0}};

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			pin_s1   <= PINS_RESET;
			pin_s2   <= PINS_RESET;
			pin_last <= PINS_RESET;
		end else begin
			pin_s1   <= pins;
			pin_s2   <= pin_s1;
			pin_last <= pin_s2;
		end
	end

	assign start = pin_last.scl && pin_s2.scl && pin_last.sda && !pin_s2.sda; // R1
	assign stop  = pin_last.scl && pin_s2.scl && !pin_last.sda && pin_s2.sda; // R2
	assign rise  = !pin_last.scl && pin_s2.scl;
	assign fall  = pin_last.scl && !pin_s2.scl;

	// ==========================================================
	// link domain: busy handshake back from the timer
	logic        req;
	logic        ack_s1;
	logic        ack_s2;
	logic        ack_t;
	logic        busy;

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= ack_t;
			ack_s2 <= ack_s1;
		end
	end

	// toggle pair: busy from the commit edge until the timer echoes it
	assign busy = req ^ ack_s2; // R10

	// ==========================================================
	// link domain: protocol engine
	link_state_t state;
	link_state_t next_state;
	logic [3:0]  bit_cnt;
	logic [3:0]  next_bit_cnt;
	logic [7:0]  shreg;
	logic [7:0]  next_shreg;
	logic [7:0]  txsh;
	logic [7:0]  next_txsh;
	logic [7:0]  ptr;
	logic [7:0]  next_ptr;
	logic [15:0] mask;
	logic [15:0] next_mask;
	logic        acking;
	logic        next_acking;
	logic        dir_read;
	logic        next_dir_read;
	logic        next_oe;
	logic        next_req;
	logic        ack_ok;
	logic        buf_we;
	logic        commit;
	logic [7:0]  mem [MEM_BYTES]; // R22
	logic [7:0]  pbuf [PAGE_BYTES];

	always_comb begin
		unique case (state)
			ST_DEV:  ack_ok = shreg[7:4] == TYPE_CODE // R5
				&& shreg[3:1] == pin_s2.sel // R6
				&& !busy; // R14 R15
			ST_WORD: ack_ok = 1'b1;
			ST_DATA: ack_ok = !pin_s2.wp; // R24
			default: ack_ok = 1'b0;
		endcase
	end

	always_comb begin
		next_state    = state;
		next_bit_cnt  = bit_cnt;
		next_shreg    = shreg;
		next_txsh     = txsh;
		next_ptr      = ptr;
		next_mask     = mask;
		next_acking   = acking;
		next_dir_read = dir_read;
		next_oe       = sda_oe;
		next_req      = req;
		buf_we        = 1'b0;
		commit        = 1'b0;
		if (start) begin
			// any start, even mid-byte, restarts address reception
			next_state   = ST_DEV; // R26 R20
			next_bit_cnt = 4'h0;
			next_acking  = 1'b0;
			next_oe      = 1'b0;
			next_mask    = 16'h0000;
		end else if (stop) begin
			next_state  = ST_IDLE; // R21
			next_oe     = 1'b0;
			next_acking = 1'b0;
			if (state == ST_DATA && mask != 16'h0000) begin
				commit    = 1'b1; // R9
				next_req  = ~req;
				next_mask = 16'h0000;
			end
		end else if (state == ST_READ) begin
			if (rise) begin
				if (bit_cnt < ACK_SLOT) begin
					next_txsh    = {txsh[6:0], 1'b0}; // R25
					next_bit_cnt = bit_cnt + 4'h1;
				end else begin
					next_ptr = ptr + 8'h01; // R17 R23
					if (pin_s2.sda) begin
						next_state = ST_IDLE; // R18
					end else begin
						next_txsh    = mem[8'(ptr + 8'h01)]; // R23
						next_bit_cnt = 4'h0;
					end
				end
			end else if (fall) begin
				next_oe = (bit_cnt < ACK_SLOT) ? ~txsh[7] : 1'b0; // R25
			end
		end else if (state != ST_IDLE) begin
			if (rise && !acking && bit_cnt < ACK_SLOT) begin
				next_shreg   = {shreg[6:0], pin_s2.sda}; // R25
				next_bit_cnt = bit_cnt + 4'h1;
			end else if (fall && acking) begin
				next_acking  = 1'b0;
				next_oe      = 1'b0;
				next_bit_cnt = 4'h0;
				if (state == ST_DEV && dir_read) begin
					next_state = ST_READ; // R16
					next_txsh  = mem[ptr];
					next_oe    = ~mem[ptr][7];
				end else if (state == ST_DEV) begin
					next_state = ST_WORD;
				end else if (state == ST_WORD) begin
					next_state = ST_DATA;
				end
			end else if (fall && bit_cnt == ACK_SLOT) begin
				if (ack_ok) begin
					next_acking = 1'b1;
					next_oe     = 1'b1; // R4
					if (state == ST_DEV) begin
						next_dir_read = shreg[0]; // R7
					end else if (state == ST_WORD) begin
						next_ptr = shreg; // R8
					end else begin
						buf_we              = 1'b1; // R11 R13
						next_mask[ptr[3:0]] = 1'b1;
						next_ptr = {ptr[7:4], 4'(ptr[3:0] + 4'h1)}; // R12
					end
				end else begin
					next_state = ST_IDLE;
				end
			end
		end
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			state    <= ST_IDLE; // R21
			bit_cnt  <= 4'h0;
			shreg    <= 8'h00;
			txsh     <= 8'h00;
			ptr      <= PTR_RESET;
			mask     <= 16'h0000;
			acking   <= 1'b0;
			dir_read <= 1'b0;
			sda_oe   <= 1'b0;
			sda_out  <= 1'b0;
			req      <= 1'b0;
		end else begin
			state    <= next_state;
			bit_cnt  <= next_bit_cnt;
			shreg    <= next_shreg;
			txsh     <= next_txsh;
			ptr      <= next_ptr;
			mask     <= next_mask;
			acking   <= next_acking;
			dir_read <= next_dir_read;
			sda_oe   <= next_oe;
			sda_out  <= 1'b0;
			req      <= next_req;
		end
	end

	// ==========================================================
	// array and page buffer; no reset, contents survive rstn
	// every buffered byte lands in one edge, the timer then hides the array
	always_ff @(posedge link_clk) begin
		if (buf_we) begin
			pbuf[ptr[3:0]] <= shreg; // R13
		end
		if (commit) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (mask[i]) begin
					mem[{ptr[7:4], 4'(i)}] <= pbuf[i]; // R9
				end
			end
		end
	end

	// ==========================================================
	// system domain: self-timed programming cycle
	logic          req_c1;
	logic          req_c2;
	logic          next_ack_t;
	logic          next_write_busy;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;

	always_comb begin
		next_ack_t      = ack_t;
		next_cnt        = cnt;
		next_write_busy = write_busy;
		if (write_busy) begin
			if (cnt == '0) begin
				next_write_busy = 1'b0; // R21
				next_ack_t      = req_c2;
			end else begin
				next_cnt = cnt - CW'(1);
			end
		end else if (req_c2 != ack_t) begin
			next_write_busy = 1'b1; // R9
			next_cnt        = CW'(WRITE_CYCLES - 1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_c1     <= 1'b0;
			req_c2     <= 1'b0;
			ack_t      <= 1'b0;
			cnt        <= '0;
			write_busy <= 1'b0;
		end else begin
			req_c1     <= req;
			req_c2     <= req_c1;
			ack_t      <= next_ack_t;
			cnt        <= next_cnt;
			write_busy <= next_write_busy;
		end
	end

	// ==========================================================
	// checks, link domain
	default clocking cb @(posedge link_clk);
	endclocking
	default disable iff (!rstn);

	chk_start_abort: assert property (start |=> state == ST_DEV && !sda_oe) // R26
		else $error("start did not return to address reception");
	chk_stop_idle: assert property (stop && !start |=> state == ST_IDLE && !sda_oe) // R2
		else $error("stop did not release the bus");
	chk_busy_nack: assert property (state == ST_DEV && fall && !acking && !start
		&& bit_cnt == ACK_SLOT && busy |=> !sda_oe [*2]) // R14
		else $error("address acked while programming");
	chk_match_ack: assert property (state == ST_DEV && fall && !acking && !start
		&& bit_cnt == ACK_SLOT && shreg[7:4] == TYPE_CODE && shreg[3:1] == pin_s2.sel
		&& !busy |=> sda_oe && acking) // R4
		else $error("matching address not acked");
	chk_type_miss: assert property (state == ST_DEV && fall && !acking && !start
		&& bit_cnt == ACK_SLOT && shreg[7:4] != TYPE_CODE |=> state == ST_IDLE) // R5
		else $error("foreign type code accepted");
	chk_page_wrap: assert property (state == ST_DATA && buf_we && !start
		|=> ptr[7:4] == $past(ptr[7:4]) && ptr[3:0] == 4'($past(ptr[3:0]) + 4'h1)) // R12
		else $error("write pointer left its page");
	chk_commit_busy: assert property (commit |=> busy ##1 busy) // R9
		else $error("commit did not start programming");
	chk_read_step: assert property (state == ST_READ && rise && bit_cnt == ACK_SLOT
		&& !start && !stop |=> ptr == 8'($past(ptr) + 8'h01)) // R23
		else $error("read counter did not advance");
	chk_wp_refuse: assert property (state == ST_DATA && fall && !acking && !start
		&& bit_cnt == ACK_SLOT && pin_s2.wp |=> !sda_oe && mask == $past(mask)) // R24
		else $error("protected write was accepted");

endmodule

`default_nettype wire

/* dv/eeprom_master.sv */
// behavioural two-wire bus master facing the eeprom slave
// assumes an external pull-up: the bench resolves sda from both pull-downs

`timescale 1ns/1ns
`default_nettype none

module eeprom_master #(
	parameter int Q = 120
) (
	output var  logic scl,
	output var  logic pull,
	input  wire logic sda
);
	// ==========================================================
	// idle bus: both lines released high
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end

	// ==========================================================
	// bus conditions
	// also serves as repeated start
	task automatic start();
		pull = 1'b0;
		#Q scl = 1'b1;
		#Q pull = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask

	task automatic stop();
		pull = 1'b1;
		#Q scl = 1'b1;
		#Q pull = 1'b0;
		#(2*Q);
	endtask

	// sda only moves while scl is low
	task automatic bit_io(input logic b, output logic r);
		pull = ~b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
		#Q;
	endtask

	// ==========================================================
	// byte transfers, msb first
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// nack on the last byte ends a read
	task automatic recv(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(~more, r);
	endtask
endmodule

`default_nettype wire

/* dv/tb_two_wire_eeprom_slave_port.sv */
// self-checking bench of the eeprom slave with a behavioural bus master
// assumes the slave's assertions are inside the design files

`timescale 1ns/1ns
`default_nettype none

module tb_two_wire_eeprom_slave_port;
	import eeprom_pkg::*;
	localparam int WCYC = 400;
	logic       clk;
	logic       link_clk;
	logic       rstn;
	logic       scl;
	logic       pull;
	logic       sda;
	logic       sda_out;
	logic       sda_oe;
	logic       wp;
	logic       write_busy;
	logic       ack;
	logic [7:0] rd;
	logic [2:0] sel;
	int         fail_count;
	int         cmp_count;

	// open-drain wire with pull-up
	assign sda = (pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

	eeprom_slave #(.WRITE_CYCLES(WCYC)) i_eeprom_slave (
		.clk(clk), .rstn(rstn), .link_clk(link_clk), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .hw_select_bit0(sel[0]),
		.hw_select_bit1(sel[1]), .hw_select_bit2(sel[2]), .write_busy(write_busy));
	eeprom_master i_eeprom_master (.scl(scl), .pull(pull), .sda(sda));

	// ==========================================================
	// clocks, unrelated in phase
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #6 link_clk = ~link_clk;
	end

	// ==========================================================
	// compare and report
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h0, got}, {7'h0, exp});
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic dev(input logic rw);
		i_eeprom_master.send({TYPE_CODE, sel, rw}, ack);
	endtask

	// ==========================================================
	// scenarios
	// page write of n bytes base+i, one nacked poll, wait for write_busy low, one acked poll
	task automatic t_write(input logic [7:0] a, input int n, input logic [7:0] base);
		i_eeprom_master.start();
		dev(1'b0);
		chk1(ack, 1'b1);
		i_eeprom_master.send(a, ack);
		chk1(ack, 1'b1);
		for (int i = 0; i < n; i++) begin
			i_eeprom_master.send(base + 8'(i), ack);
			chk1(ack, 1'b1);
		end
		i_eeprom_master.stop();
		repeat (10) @(posedge clk);
		#1;
		chk1(write_busy, 1'b1);
		i_eeprom_master.start();
		dev(1'b0);
		chk1(ack, 1'b0);
		i_eeprom_master.stop();
		// the busy span is the whole timer, not a few cycles
		for (int k = 0; k < WCYC + 20 && write_busy !== 1'b0; k++) @(posedge clk);
		chk1(write_busy, 1'b0);
		repeat (10) @(posedge clk);
		#1;
		i_eeprom_master.start();
		dev(1'b0);
		chk1(ack, 1'b1);
		i_eeprom_master.stop();
		$display("write at %h done", a);
	endtask

	// dummy write then repeated start
	task automatic t_rand(input logic [7:0] a);
		i_eeprom_master.start();
		dev(1'b0);
		i_eeprom_master.send(a, ack);
		i_eeprom_master.start();
		dev(1'b1);
		chk1(ack, 1'b1);
	endtask

	task automatic t_reads();
		t_rand(8'h2d);
		i_eeprom_master.recv(1'b1, rd);
		chk8(rd, 8'h4f);
		i_eeprom_master.recv(1'b1, rd);
		chk8(rd, 8'h50);
		i_eeprom_master.recv(1'b0, rd);
		chk8(rd, 8'h51);
		i_eeprom_master.stop();
		t_rand(8'h20);
		i_eeprom_master.recv(1'b0, rd);
		chk8(rd, 8'h42);
		i_eeprom_master.stop();
		t_rand(8'hff);
		i_eeprom_master.recv(1'b0, rd);
		chk8(rd, 8'h5a);
		i_eeprom_master.stop();
		i_eeprom_master.start();
		dev(1'b1);
		chk1(ack, 1'b1);
		i_eeprom_master.recv(1'b0, rd);
		chk8(rd, 8'ha1);
		i_eeprom_master.stop();
		$display("reads done");
	endtask

	// wrong type, wrong select, protected data
	task automatic t_refuse();
		i_eeprom_master.start();
		i_eeprom_master.send({4'hb, sel, 1'b0}, ack);
		chk1(ack, 1'b0);
		i_eeprom_master.start();
		i_eeprom_master.send({TYPE_CODE, sel ^ 3'h2, 1'b0}, ack);
		chk1(ack, 1'b0);
		i_eeprom_master.stop();
		// cut an address byte after two bits
		i_eeprom_master.start();
		i_eeprom_master.bit_io(1'b1, ack);
		i_eeprom_master.bit_io(1'b0, ack);
		i_eeprom_master.start();
		dev(1'b0);
		chk1(ack, 1'b1);
		i_eeprom_master.stop();
		wp = 1'b1;
		i_eeprom_master.start();
		dev(1'b0);
		i_eeprom_master.send(8'h40, ack);
		i_eeprom_master.send(8'h99, ack);
		chk1(ack, 1'b0);
		i_eeprom_master.stop();
		repeat (10) @(posedge clk);
		chk1(write_busy, 1'b0);
		wp = 1'b0;
		$display("refusals done");
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		fail_count = 0;
		cmp_count = 0;
		rstn = 1'b0;
		wp = 1'b0;
		sel = 3'h5;
		repeat (10) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		t_write(8'h0f, 2, 8'ha0);
		t_write(8'hff, 1, 8'h5a);
		t_write(8'h2e, 18, 8'h40);
		t_refuse();
		t_reads();
		test_done();
	end

	// whole run needs well under half a millisecond
	initial begin
		#1000000;
		fail_count++;
		test_done();
	end
endmodule

`default_nettype wire
